// ==== bench/ch5_cal_cfg_register_map_checksum_bench.sv ====
// Self-checking bench for the channel-five register slice
`timescale 1ns/1ps
module ch5_cal_cfg_register_map_checksum_bench;
  import ch5_regs_pkg::*;
  localparam logic [5:0] ADDRS [8] = '{6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h3E, 6'h3F, 6'h10};
  logic        clk, resetn, clkEn, chkLoad, glob, smpV, regWrite, regHit, resV;
  logic        dcAct, pins, shrt, tpos, tneg;
  logic [5:0]  regAddr;
  logic [15:0] wData, rData, chkIn;
  logic signed [23:0] smpIn, resOut;
  logic signed [9:0]  phase;
  int          fails, cmp_count;
  ch5_cal_cfg_register_map_checksum u_ch5_cal_cfg_register_map_checksum (.clk(clk), .resetn(resetn), .clkEn(clkEn),
    .regWrite(regWrite), .regAddr(regAddr), .regWriteData(wData), .regReadData(rData),
    .regHit(regHit), .checksumIn(chkIn), .checksumLoad(chkLoad), .global_dc_filter_setting(glob),
    .ch_five_dc_filter_active(dcAct), .ch_five_phase_delay(phase), .ch_five_use_pins(pins),
    .ch_five_short_inputs(shrt), .ch_five_test_pos(tpos), .ch_five_test_neg(tneg),
    .sampleValid(smpV), .sampleIn(smpIn), .resultValid(resV), .resultOut(resOut));
  ch5_host_model u_ch5_host_model (.clk(clk), .regWrite(regWrite), .regAddr(regAddr),
    .regWriteData(wData), .regReadData(rData));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Readback after a write: read-only bits and unmapped places give zero
  function automatic logic [15:0] keep(input logic [5:0] a, input logic [15:0] d);
    case (a)
      6'h22: return d & 16'hFFC7;
      6'h23, 6'h25: return d;
      6'h24, 6'h26: return d & 16'hFF00;
      default: return 16'h0000;
    endcase
  endfunction
  function automatic logic [23:0] trim(input int s, input int o, input int unsigned g);
    longint p;
    p = ((longint'(s) + o) * longint'(g)) >>> GAIN_FRAC_BITS;
    if (p > 64'sh7FFFFF) p = 64'sh7FFFFF;
    if (p < -64'sh800000) p = -64'sh800000;
    return 24'(p);
  endfunction
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #2000000;
    fails++;
    print_verdict();
  end
  initial begin
    logic [5:0] a;
    logic [15:0] d, q;
    int s, o;
    int unsigned g;
    {resetn, chkLoad, glob, smpV, chkIn, smpIn} = '0;
    clkEn = 1'b1;
    void'($urandom(32'h0F02));
    repeat (2) @(posedge clk);
    #1 resetn = 1'b1;
    foreach (ADDRS[i]) begin
      u_ch5_host_model.read_reg(ADDRS[i], q);
      check(q, (ADDRS[i] == 6'h25) ? 16'h8000 : 16'h0000);
      check(regHit, ADDRS[i] != 6'h10);
    end
    $display("test 1 done");
    for (int i = 0; i < 24; i++) begin
      a = ADDRS[(i < 8) ? i : $urandom_range(7)];
      d = (i < 8) ? 16'hFFFF : 16'($urandom);
      u_ch5_host_model.write_reg(a, d);
      u_ch5_host_model.read_reg(a, q);
      check(q, keep(a, d));
    end
    $display("test 2 done");
    d = 16'($urandom);
    @(posedge clk) #1 chkIn = d;
    chkLoad = 1'b1;
    @(posedge clk) #1 chkLoad = 1'b0;
    u_ch5_host_model.read_reg(REGISTER_MAP_CHECKSUM_ADDR, q);
    check(q, d);
    u_ch5_host_model.write_reg(6'h23, 16'h1234);
    clkEn = 1'b0;
    u_ch5_host_model.write_reg(6'h23, 16'hABCD);
    clkEn = 1'b1;
    u_ch5_host_model.read_reg(6'h23, q);
    check(q, 16'h1234);
    $display("test 3 done");
    for (int m = 0; m < 8; m++) begin
      d = {10'($urandom), 3'h0, 3'(m)};
      glob = 1'($urandom_range(1));
      u_ch5_host_model.write_reg(CHANNEL5_CONFIG_ADDR, d);
      check($unsigned(phase), d[15:6]);
      check({tneg, tpos, shrt, pins}, 4'h1 << d[1:0]);
      check(dcAct, glob & ~d[2]);
    end
    $display("test 4 done");
    for (int i = 0; i < 10; i++) begin
      s = (i == 0) ? 32'sh7FFFFF : int'($urandom_range(32'h1FFFFF)) - 32'sh100000;
      o = (i == 0) ? 0 : int'($urandom_range(32'h1FFFFF)) - 32'sh100000;
      g = (i == 0) ? 32'hFFFFFF : $urandom_range(32'hFFFFFF);
      u_ch5_host_model.write_reg(6'h23, 16'(o >>> 8));
      u_ch5_host_model.write_reg(6'h24, {8'(o), 8'h00});
      u_ch5_host_model.write_reg(6'h25, 16'(g >> 8));
      u_ch5_host_model.write_reg(6'h26, {8'(g), 8'h00});
      @(posedge clk) #1 smpV = 1'b1;
      smpIn = 24'(s);
      @(posedge clk) #1 smpV = 1'b0;
      for (int k = 0; k < 4 && resV !== 1'b1; k++) @(posedge clk) #1;
      check(resV, 1'b1);
      check(resOut, trim(s, o, g));
    end
    $display("test 5 done");
    // Reset in mid-run must bring the gain word back to unity
    u_ch5_host_model.write_reg(6'h25, 16'h1357);
    @(posedge clk) #1 resetn = 1'b0;
    repeat (2) @(posedge clk);
    #1 resetn = 1'b1;
    u_ch5_host_model.read_reg(6'h25, q);
    check(q, 16'h8000);
    $display("test 6 done");
    print_verdict();
  end
endmodule // ch5_cal_cfg_register_map_checksum_bench

// ==== bench/ch5_host_model.sv ====
// Host model issuing register writes and reads
`timescale 1ns/1ps
module ch5_host_model (
  input wire logic                               clk,
  output logic                                   regWrite,
  output logic      [ch5_regs_pkg::ADDR_WIDTH-1:0] regAddr,
  output logic      [ch5_regs_pkg::DATA_WIDTH-1:0] regWriteData,
  input wire logic  [ch5_regs_pkg::DATA_WIDTH-1:0] regReadData
);
  import ch5_regs_pkg::*;
  initial begin
    regWrite = 1'b0;
    regAddr = 6'h00;
    regWriteData = 16'h0000;
  end
  task automatic write_reg(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk) #1;
    regWrite = 1'b1;
    regAddr = a;
    regWriteData = (a == TOP_RESERVED_WORD_ADDR) ? 16'h0000 : d;
    @(posedge clk) #1;
    regWrite = 1'b0;
    // Released data flips so a stale word never looks like a fresh write
    regWriteData = ~regWriteData;
  endtask
  task automatic read_reg(input logic [5:0] a, output logic [15:0] q);
    @(posedge clk) #1;
    regAddr = a;
    @(posedge clk) #1;
    q = regReadData;
  endtask
endmodule // ch5_host_model

// ==== bench/ch5_regs_checker.sv ====
// Assertion checker for the channel-five register slice
`timescale 1ns/1ps
module ch5_regs_checker (
  input wire logic                                 clk,
  input wire logic                                 resetn,
  input wire logic                                 clkEn,
  input wire logic                                 regWrite,
  input wire logic        [ch5_regs_pkg::ADDR_WIDTH-1:0]  regAddr,
  input wire logic        [ch5_regs_pkg::DATA_WIDTH-1:0]  regWriteData,
  input wire logic        [ch5_regs_pkg::DATA_WIDTH-1:0]  regReadData,
  input wire logic                                 regHit,
  input wire logic                                 global_dc_filter_setting,
  input wire logic                                 ch_five_dc_filter_active,
  input wire logic signed [ch5_regs_pkg::PHASE_WIDTH-1:0] ch_five_phase_delay,
  input wire logic                                 ch_five_use_pins,
  input wire logic                                 ch_five_short_inputs,
  input wire logic                                 ch_five_test_pos,
  input wire logic                                 ch_five_test_neg,
  input wire logic                                 sampleValid,
  input wire logic                                 resultValid
);
  import ch5_regs_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence cfg_wr;
    clkEn && regWrite && regAddr == CHANNEL5_CONFIG_ADDR;
  endsequence
  sequence smp_taken;
    sampleValid && clkEn ##1 clkEn;
  endsequence
  dc_follow_a: assert property (cfg_wr |=> ch_five_dc_filter_active ==
    (global_dc_filter_setting && !$past(regWriteData[OPTOUT_BIT]))) else $error("dc filter wrong");
  phase_load_a: assert property (cfg_wr |=> ch_five_phase_delay ==
    $past(regWriteData[PHASE_MSB:PHASE_LSB])) else $error("phase delay wrong");
  select_decode_a: assert property (cfg_wr |=> {ch_five_test_neg, ch_five_test_pos,
    ch_five_short_inputs, ch_five_use_pins} == 4'h1 << $past(regWriteData[1:0]))
    else $error("input select wrong");
  cfg_gap_zero_a: assert property (clkEn && regAddr == CHANNEL5_CONFIG_ADDR
    |=> regReadData[5:3] == 3'h0) else $error("config gap not zero");
  low_byte_zero_a: assert property (clkEn && (regAddr == CHANNEL5_OFFSET_TRIM_LOW_ADDR
    || regAddr == CHANNEL5_GAIN_TRIM_LOW_ADDR) |=> regReadData[7:0] == 8'h00)
    else $error("low byte not zero");
  hit_decode_a: assert property (regHit == (regAddr inside {[6'h22:6'h26], 6'h3E, 6'h3F}))
    else $error("address decode wrong");
  result_after_two_a: assert property (smp_taken |=> resultValid)
    else $error("result late");
  result_pulse_a: assert property (resultValid && clkEn |=> !resultValid)
    else $error("result held");
  frozen_hold_a: assert property (!clkEn |=> $stable(ch_five_phase_delay))
    else $error("phase moved while frozen");
endmodule // ch5_regs_checker

bind ch5_cal_cfg_register_map_checksum ch5_regs_checker u_ch5_regs_checker (.clk, .resetn, .clkEn,
  .regWrite, .regAddr, .regWriteData, .regReadData, .regHit, .global_dc_filter_setting,
  .ch_five_dc_filter_active, .ch_five_phase_delay, .ch_five_use_pins, .ch_five_short_inputs,
  .ch_five_test_pos, .ch_five_test_neg, .sampleValid, .resultValid);

// ==== verilog/ch5_cal_cfg_register_map_checksum.sv ====
// Channel-five configuration and calibration registers, checksum and reserved word
`timescale 1ns/1ps
module ch5_cal_cfg_register_map_checksum (
  input  wire logic                                         clk,
  input  wire logic                                         resetn,
  input  wire logic                                         clkEn,
  input  wire logic                                         regWrite,
  input  wire logic        [ch5_regs_pkg::ADDR_WIDTH-1:0]   regAddr,
  input  wire logic        [ch5_regs_pkg::DATA_WIDTH-1:0]   regWriteData,
  output logic             [ch5_regs_pkg::DATA_WIDTH-1:0]   regReadData,
  output logic                                              regHit,
  input  wire logic        [ch5_regs_pkg::DATA_WIDTH-1:0]   checksumIn,
  input  wire logic                                         checksumLoad,
  input  wire logic                                         global_dc_filter_setting,
  output logic                                              ch_five_dc_filter_active,
  output logic signed      [ch5_regs_pkg::PHASE_WIDTH-1:0]  ch_five_phase_delay,
  output logic                                              ch_five_use_pins,
  output logic                                              ch_five_short_inputs,
  output logic                                              ch_five_test_pos,
  output logic                                              ch_five_test_neg,
  input  wire logic                                         sampleValid,
  input  wire logic signed [ch5_regs_pkg::SAMPLE_WIDTH-1:0] sampleIn,
  output logic                                              resultValid,
  output logic signed      [ch5_regs_pkg::SAMPLE_WIDTH-1:0] resultOut
);
  import ch5_regs_pkg::*;

  logic [PHASE_WIDTH-1:0] phaseField;
  logic                   ch_five_dc_filter_optout;
  logic [1:0]             ch_five_input_select;
  logic [DATA_WIDTH-1:0]  ch_five_offset_high;
  logic [7:0]             ch_five_offset_low;
  logic [DATA_WIDTH-1:0]  ch_five_gain_high;
  logic [7:0]             ch_five_gain_low;
  logic [DATA_WIDTH-1:0]  checksumWord;
  logic [DATA_WIDTH-1:0]  reservedWord;

  wire hitConfig     = regAddr == CHANNEL5_CONFIG_ADDR;
  wire hitOffsetHigh = regAddr == CHANNEL5_OFFSET_TRIM_HIGH_ADDR;
  wire hitOffsetLow  = regAddr == CHANNEL5_OFFSET_TRIM_LOW_ADDR;
  wire hitGainHigh   = regAddr == CHANNEL5_GAIN_TRIM_HIGH_ADDR;
  wire hitGainLow    = regAddr == CHANNEL5_GAIN_TRIM_LOW_ADDR;
  wire hitChecksum   = regAddr == REGISTER_MAP_CHECKSUM_ADDR;
  wire hitReserved   = regAddr == TOP_RESERVED_WORD_ADDR;

  wire writeEn = regWrite && clkEn;

  wire [DATA_WIDTH-1:0] configWord;
  wire [DATA_WIDTH-1:0] offsetLowWord;
  wire [DATA_WIDTH-1:0] gainLowWord;
  wire [DATA_WIDTH-1:0] next_readData;

  // Reserved config bits are never stored, so they always read zero
  assign configWord = {phaseField, 3'b000, ch_five_dc_filter_optout,
                       ch_five_input_select};
  assign offsetLowWord = {ch_five_offset_low, 8'h00};
  assign gainLowWord = {ch_five_gain_low, 8'h00};

  assign next_readData =
    hitConfig     ? configWord :
    hitOffsetHigh ? ch_five_offset_high :
    hitOffsetLow  ? offsetLowWord :
    hitGainHigh   ? ch_five_gain_high :
    hitGainLow    ? gainLowWord :
    hitChecksum   ? checksumWord :
    hitReserved   ? reservedWord :
    16'h0000;

  assign regHit = hitConfig || hitOffsetHigh || hitOffsetLow || hitGainHigh ||
                  hitGainLow || hitChecksum || hitReserved;

  // Config word
  always_ff @(posedge clk) begin
    if (!resetn) begin
      phaseField               <= CHANNEL5_CONFIG_RESET[PHASE_MSB:PHASE_LSB];
      ch_five_dc_filter_optout <= CHANNEL5_CONFIG_RESET[OPTOUT_BIT];
      ch_five_input_select     <= CHANNEL5_CONFIG_RESET[SELECT_MSB:SELECT_LSB];
    end else if (writeEn && hitConfig) begin
      phaseField               <= regWriteData[PHASE_MSB:PHASE_LSB];
      ch_five_dc_filter_optout <= regWriteData[OPTOUT_BIT];
      ch_five_input_select     <= regWriteData[SELECT_MSB:SELECT_LSB];
    end
  end

  // Offset trim words
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ch_five_offset_high <= CHANNEL5_OFFSET_TRIM_HIGH_RESET;
      ch_five_offset_low  <= CHANNEL5_OFFSET_TRIM_LOW_RESET[LOW_BYTE_MSB:LOW_BYTE_LSB];
    end else if (writeEn) begin
      if (hitOffsetHigh) begin
        ch_five_offset_high <= regWriteData;
      end
      if (hitOffsetLow) begin
        ch_five_offset_low <= regWriteData[LOW_BYTE_MSB:LOW_BYTE_LSB];
      end
    end
  end

  // Gain trim words
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ch_five_gain_high <= CHANNEL5_GAIN_TRIM_HIGH_RESET;
      ch_five_gain_low  <= CHANNEL5_GAIN_TRIM_LOW_RESET[LOW_BYTE_MSB:LOW_BYTE_LSB];
    end else if (writeEn) begin
      if (hitGainHigh) begin
        ch_five_gain_high <= regWriteData;
      end
      if (hitGainLow) begin
        ch_five_gain_low <= regWriteData[LOW_BYTE_MSB:LOW_BYTE_LSB];
      end
    end
  end

  // Checksum is loaded only by the map checker; host writes are dropped
  always_ff @(posedge clk) begin
    if (!resetn) begin
      checksumWord <= REGISTER_MAP_CHECKSUM_RESET;
    end else if (clkEn && checksumLoad) begin
      checksumWord <= checksumIn;
    end
  end

  // Stored as written; the host keeps it zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reservedWord <= TOP_RESERVED_WORD_RESET;
    end else if (writeEn && hitReserved) begin
      reservedWord <= regWriteData;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      regReadData <= '0;
    end else if (clkEn) begin
      regReadData <= next_readData;
    end
  end

  // Channel controls
  assign ch_five_phase_delay = $signed(phaseField);
  assign ch_five_dc_filter_active = global_dc_filter_setting && !ch_five_dc_filter_optout;
  assign ch_five_use_pins     = ch_five_input_select == SELECT_PINS;
  assign ch_five_short_inputs = ch_five_input_select == SELECT_SHORTED;
  assign ch_five_test_pos     = ch_five_input_select == SELECT_TEST_POS;
  assign ch_five_test_neg     = ch_five_input_select == SELECT_TEST_NEG;

  wire signed [TRIM_WIDTH-1:0] offsetTrim = $signed({ch_five_offset_high, ch_five_offset_low});
  wire        [TRIM_WIDTH-1:0] gainTrim = {ch_five_gain_high, ch_five_gain_low};

  ch5_trim_path trimPath (
    .clk         (clk),
    .resetn      (resetn),
    .clkEn       (clkEn),
    .sampleValid (sampleValid),
    .sampleIn    (sampleIn),
    .offsetTrim  (offsetTrim),
    .gainTrim    (gainTrim),
    .resultValid (resultValid),
    .resultOut   (resultOut)
  );
endmodule // ch5_cal_cfg_register_map_checksum

// ==== verilog/ch5_regs_pkg.sv ====
// Package with the channel-five register map constants and types
package ch5_regs_pkg;
  localparam int unsigned ADDR_WIDTH = 6;
  localparam int unsigned DATA_WIDTH = 16;
  localparam int unsigned TRIM_WIDTH = 24;
  localparam int unsigned SAMPLE_WIDTH = 24;
  localparam int unsigned PHASE_WIDTH = 10;

  localparam logic [ADDR_WIDTH-1:0] CHANNEL5_CONFIG_ADDR           = 6'h22;
  localparam logic [ADDR_WIDTH-1:0] CHANNEL5_OFFSET_TRIM_HIGH_ADDR = 6'h23;
  localparam logic [ADDR_WIDTH-1:0] CHANNEL5_OFFSET_TRIM_LOW_ADDR  = 6'h24;
  localparam logic [ADDR_WIDTH-1:0] CHANNEL5_GAIN_TRIM_HIGH_ADDR   = 6'h25;
  localparam logic [ADDR_WIDTH-1:0] CHANNEL5_GAIN_TRIM_LOW_ADDR    = 6'h26;
  localparam logic [ADDR_WIDTH-1:0] REGISTER_MAP_CHECKSUM_ADDR     = 6'h3E;
  localparam logic [ADDR_WIDTH-1:0] TOP_RESERVED_WORD_ADDR         = 6'h3F;

  localparam logic [DATA_WIDTH-1:0] CHANNEL5_CONFIG_RESET           = 16'h0000;
  localparam logic [DATA_WIDTH-1:0] CHANNEL5_OFFSET_TRIM_HIGH_RESET = 16'h0000;
  localparam logic [DATA_WIDTH-1:0] CHANNEL5_OFFSET_TRIM_LOW_RESET  = 16'h0000;
  localparam logic [DATA_WIDTH-1:0] CHANNEL5_GAIN_TRIM_HIGH_RESET   = 16'h8000;
  localparam logic [DATA_WIDTH-1:0] CHANNEL5_GAIN_TRIM_LOW_RESET    = 16'h0000;
  localparam logic [DATA_WIDTH-1:0] REGISTER_MAP_CHECKSUM_RESET     = 16'h0000;
  localparam logic [DATA_WIDTH-1:0] TOP_RESERVED_WORD_RESET         = 16'h0000;

  // Config word fields
  localparam int unsigned PHASE_MSB = 15;
  localparam int unsigned PHASE_LSB = 6;
  localparam int unsigned OPTOUT_BIT = 2;
  localparam int unsigned SELECT_MSB = 1;
  localparam int unsigned SELECT_LSB = 0;
  // Writable byte of each trim low word
  localparam int unsigned LOW_BYTE_MSB = 15;
  localparam int unsigned LOW_BYTE_LSB = 8;
  // Gain is a fraction with this many bits below unity
  localparam int unsigned GAIN_FRAC_BITS = 23;

  typedef enum logic [1:0] {
    SELECT_PINS      = 2'b00,
    SELECT_SHORTED   = 2'b01,
    SELECT_TEST_POS  = 2'b10,
    SELECT_TEST_NEG  = 2'b11
  } input_select_type;

  typedef enum logic [1:0] {
    TRIM_IDLE   = 2'b00,
    TRIM_OFFSET = 2'b01,
    TRIM_GAIN   = 2'b10
  } trim_state_type;
endpackage

// ==== verilog/ch5_trim_path.sv ====
// Offset then gain correction of one conversion result, registered in two steps
`timescale 1ns/1ps
module ch5_trim_path (
  input  wire logic                                   clk,
  input  wire logic                                   resetn,
  input  wire logic                                   clkEn,
  input  wire logic                                   sampleValid,
  input  wire logic signed [ch5_regs_pkg::SAMPLE_WIDTH-1:0] sampleIn,
  input  wire logic signed [ch5_regs_pkg::TRIM_WIDTH-1:0]   offsetTrim,
  input  wire logic        [ch5_regs_pkg::TRIM_WIDTH-1:0]   gainTrim,
  output logic                                        resultValid,
  output logic signed      [ch5_regs_pkg::SAMPLE_WIDTH-1:0] resultOut
);
  import ch5_regs_pkg::*;

  localparam logic signed [SAMPLE_WIDTH+1:0] MAX_VAL = {3'b000, {(SAMPLE_WIDTH-1){1'b1}}};
  localparam logic signed [SAMPLE_WIDTH+1:0] MIN_VAL = {3'b111, {(SAMPLE_WIDTH-1){1'b0}}};

  trim_state_type state;
  logic signed [SAMPLE_WIDTH+1:0] offsetSum;
  wire  signed [SAMPLE_WIDTH+1:0] rawSum;
  wire  signed [SAMPLE_WIDTH+TRIM_WIDTH+2:0] product;
  wire  signed [SAMPLE_WIDTH+TRIM_WIDTH+2:0] scaled;
  wire  signed [SAMPLE_WIDTH+1:0] scaledNarrow;
  wire  signed [SAMPLE_WIDTH+1:0] clipped;
  wire         overHigh;
  wire         overLow;

  // Offset added first, with guard bits so the sum cannot wrap
  assign rawSum = (SAMPLE_WIDTH+2)'(sampleIn) + (SAMPLE_WIDTH+2)'(offsetTrim);
  // Gain is unsigned, so it is widened with a zero sign bit
  assign product = (SAMPLE_WIDTH+TRIM_WIDTH+3)'(offsetSum) * $signed({1'b0, gainTrim});
  assign scaled = product >>> GAIN_FRAC_BITS;
  assign overHigh = scaled > (SAMPLE_WIDTH+TRIM_WIDTH+3)'(MAX_VAL);
  assign overLow = scaled < (SAMPLE_WIDTH+TRIM_WIDTH+3)'(MIN_VAL);
  assign scaledNarrow = scaled[SAMPLE_WIDTH+1:0];
  // Saturate rather than wrap: a wrapped result flips sign
  assign clipped = overHigh ? MAX_VAL : (overLow ? MIN_VAL : scaledNarrow);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state       <= TRIM_IDLE;
      offsetSum   <= '0;
      resultValid <= 1'b0;
      resultOut   <= '0;
    end else if (clkEn) begin
      resultValid <= 1'b0;
      case (state)
        TRIM_IDLE: begin
          if (sampleValid) begin
            offsetSum <= rawSum;
            state     <= TRIM_OFFSET;
          end
        end
        TRIM_OFFSET: begin
          resultOut   <= clipped[SAMPLE_WIDTH-1:0];
          resultValid <= 1'b1;
          state       <= TRIM_IDLE;
        end
        default: state <= TRIM_IDLE;
      endcase
    end
  end
endmodule // ch5_trim_path
